// ---- design/drsc_pkg.sv ----
// constants and types shared by the status-output and start-control block
package drsc_pkg;
    // ==========================================================
    // percent quantities, in tenths of a percent
    localparam int          PCT_W        = 12;
    localparam logic [11:0] PCT_MAX      = 12'h7d0; // 200.0 %
    localparam logic [11:0] PCT_DEFAULT  = 12'h3e8; // 100.0 %
    localparam logic [11:0] PCT_ZERO     = 12'h000;

    // ==========================================================
    // function select codes, shared by digital output and relay
    localparam logic [3:0] FN_ENABLED    = 4'h0;
    localparam logic [3:0] FN_HEALTHY    = 4'h1;
    localparam logic [3:0] FN_AT_SPEED   = 4'h2;
    localparam logic [3:0] FN_SPEED_NZ   = 4'h3;
    localparam logic [3:0] FN_CMP_SPEED  = 4'h4;
    localparam logic [3:0] FN_CMP_TORQUE = 4'h5;
    localparam logic [3:0] FN_CMP_AIN2   = 4'h6;
    localparam logic [3:0] RELAY_FN_DEFAULT = FN_HEALTHY;

    // relay polarity
    localparam logic POL_NORMALLY_OPEN   = 1'b0;

    // ==========================================================
    // start mode codes: 0 edge, 1 auto-0, 2..6 auto with 1..5 retries
    localparam logic [2:0] START_EDGE    = 3'h0;
    localparam logic [2:0] START_AUTO0   = 3'h1;
    localparam logic [2:0] START_DEFAULT = START_AUTO0;
    localparam logic [2:0] START_MAX     = 3'h6;

    // ==========================================================
    // timing: one slow tick is 100 ms
    localparam int CLK_MHZ          = 200;
    localparam int TICK_MS          = 100;
    localparam int TICK_CYCLES      = TICK_MS * 1000 * CLK_MHZ;
    localparam int RETRY_INTERVAL_S = 20;
    localparam logic [9:0] RETRY_TICKS =
        10'(RETRY_INTERVAL_S * 1000 / TICK_MS);
    // hold time in ticks (tenths of a second)
    localparam logic [9:0] HOLD_MAX     = 10'h258; // 60.0 s
    localparam logic [9:0] HOLD_DEFAULT = 10'h002; // 0.2 s
    localparam logic [9:0] TICKS_ZERO   = 10'h000;

    // ==========================================================
    // sequencer states
    typedef enum logic [2:0] {
        SEQ_RESET = 3'b000,
        SEQ_ARM   = 3'b001,
        SEQ_IDLE  = 3'b010,
        SEQ_RUN   = 3'b011,
        SEQ_HOLD  = 3'b100,
        SEQ_FAULT = 3'b101
    } drsc_seq_t;
endpackage

// ---- design/drsc_cmp_if.sv ----
// carrier between the top and a hysteresis comparator
`timescale 1ns/1ps
interface drsc_cmp_if;
    logic [11:0] value;
    logic [11:0] high_lim;
    logic [11:0] low_lim;
    logic        valid;
    logic        level;

    modport cmp  (input value, input high_lim, input low_lim,
                  input valid, output level);
    modport user (output value, output high_lim, output low_lim,
                  output valid, input level);
endinterface

// ---- design/drsc_hyst_cmp.sv ----
// hysteresis comparator with limit clamping
`timescale 1ns/1ps
module drsc_hyst_cmp (
    // clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // comparison port
    drsc_cmp_if.cmp    cmp
);
    // ==========================================================
    // limit clamping
    logic [11:0] high_c;
    logic [11:0] low_c;
    logic        level_q;
    logic        level_d;

    // high limit held to 200.0 %, low limit held to high limit
    assign high_c = (cmp.high_lim > drsc_pkg::PCT_MAX) ?
                    drsc_pkg::PCT_MAX : cmp.high_lim; // RULE5
    assign low_c  = (cmp.low_lim > high_c) ?
                    high_c : cmp.low_lim; // RULE13

    // ==========================================================
    // set above high, clear below low, else hold
    assign level_d = !cmp.valid ? level_q :
                     (cmp.value > high_c) ? 1'b1 :
                     (cmp.value < low_c)  ? 1'b0 : level_q;

    // output low from reset until a valid sample arrives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_q <= 1'b0; // RULE14
        end else begin
            level_q <= level_d; // RULE1 RULE4
        end
    end

    assign cmp.level = level_q;
endmodule

// ---- design/drsc_top.sv ----
// status outputs, zero-speed hold and start sequencer of a motor drive
// Notes on behaviour
// RULE1: digout codes 4-6: set above high limit, clear only below low limit.
// RULE2: relay codes: 0 running, 1 no fault, 2 at setpoint, 3 speed>0.
// RULE3: relay codes 4,5,6 compare speed, torque, second analog input.
// RULE4: relay comparator sets above relay high, clears below relay low.
// RULE5: high limits 0.0-200.0 %, default 100.0; low limits default 100.0.
// RULE6: relay polarity 0 closes contacts on logic one, 1 opens them.
// RULE7: on stop hold zero speed for hold time, then disable output.
// RULE8: edge mode: run input must open then close after reset.
// RULE9: auto mode default: start after reset whenever run input closed.
// RULE10: auto 1-5: after fault retry up to N times, 20 s apart.
// RULE11: restart counter cleared only by power-down reset.
// RULE12: standby permitted only while hold time is zero.
// RULE13: low limit above high limit is clamped to the high limit.
// RULE14: comparator outputs low after reset until first valid sample.
`timescale 1ns/1ps
module drsc_top #(
    parameter int TICK_CYCLES = drsc_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // configuration
    input  wire logic [3:0]  digout_function_select_i,
    input  wire logic [11:0] digout_high_limit_i,
    input  wire logic [11:0] digout_low_limit_i,
    input  wire logic [3:0]  relay_function_select_i,
    input  wire logic [11:0] relay_high_limit_i,
    input  wire logic [11:0] relay_low_limit_i,
    input  wire logic        relay_polarity_i,
    input  wire logic [9:0]  zero_speed_hold_time_i,
    input  wire logic [2:0]  start_mode_select_i,
    // drive conditions, same clock
    input  wire logic [11:0] speed_pct_i,
    input  wire logic [11:0] torque_pct_i,
    input  wire logic [11:0] ain2_pct_i,
    input  wire logic        sample_valid_i,
    input  wire logic        at_setpoint_i,
    input  wire logic        fault_i,
    input  wire logic        fault_reset_i,
    // run input pin
    input  wire logic        run_input_i,
    // outputs
    output logic             digout_o,
    output logic             relay_contact_o,
    output logic             drive_run_o,
    output logic             zero_speed_hold_o,
    output logic [2:0]       restart_count_o,
    output logic             standby_allowed_o
);
    // ==========================================================
    // quantity selection for a comparator code
    function automatic logic [11:0] sel_qty(input logic [3:0] code,
                                             input logic [11:0] spd,
                                             input logic [11:0] trq,
                                             input logic [11:0] ain);
        case (code)
            drsc_pkg::FN_CMP_SPEED:  sel_qty = spd;
            drsc_pkg::FN_CMP_TORQUE: sel_qty = trq;
            default:                 sel_qty = ain;
        endcase
    endfunction

    function automatic logic is_cmp(input logic [3:0] code);
        is_cmp = (code >= drsc_pkg::FN_CMP_SPEED) &&
                 (code <= drsc_pkg::FN_CMP_AIN2);
    endfunction

    // ==========================================================
    // run input synchroniser; keeps tracking the pin through reset so
    // that a contact held closed is already seen when reset ends
    logic run_meta_q;
    logic run_sync_q;

    always_ff @(posedge core_clk_i) begin
        run_meta_q <= run_input_i;
        run_sync_q <= run_meta_q; // RULE8
    end

    // ==========================================================
    // slow tick generator
    logic [31:0] tick_cnt_q;
    logic        tick;

    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tick_cnt_q <= 32'h0;
        end else if (tick) begin
            tick_cnt_q <= 32'h0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
        end
    end

    // ==========================================================
    // comparators
    drsc_cmp_if dig_cmp ();
    drsc_cmp_if rly_cmp ();

    assign dig_cmp.value    = sel_qty(digout_function_select_i,
                                      speed_pct_i, torque_pct_i,
                                      ain2_pct_i);
    assign dig_cmp.high_lim = digout_high_limit_i;
    assign dig_cmp.low_lim  = digout_low_limit_i;
    assign dig_cmp.valid    = sample_valid_i &&
                              is_cmp(digout_function_select_i); // RULE1
    assign rly_cmp.value    = sel_qty(relay_function_select_i,
                                      speed_pct_i, torque_pct_i,
                                      ain2_pct_i); // RULE3
    assign rly_cmp.high_lim = relay_high_limit_i;
    assign rly_cmp.low_lim  = relay_low_limit_i;
    assign rly_cmp.valid    = sample_valid_i &&
                              is_cmp(relay_function_select_i); // RULE4

    drsc_hyst_cmp u_dig_cmp (
        .clk_i (core_clk_i),
        .rst_i (rst_i),
        .cmp   (dig_cmp.cmp)
    );

    drsc_hyst_cmp u_rly_cmp (
        .clk_i (core_clk_i),
        .rst_i (rst_i),
        .cmp   (rly_cmp.cmp)
    );

    // ==========================================================
    // function mapping for both status outputs
    logic speed_nz;
    logic dig_level;
    logic rly_level;

    function automatic logic map_fn(input logic [3:0] code,
                                    input logic run,
                                    input logic flt,
                                    input logic at_sp,
                                    input logic nz,
                                    input logic cmp_lvl);
        case (code)
            drsc_pkg::FN_ENABLED:    map_fn = run;
            drsc_pkg::FN_HEALTHY:    map_fn = !flt;
            drsc_pkg::FN_AT_SPEED:   map_fn = at_sp;
            drsc_pkg::FN_SPEED_NZ:   map_fn = nz;
            drsc_pkg::FN_CMP_SPEED,
            drsc_pkg::FN_CMP_TORQUE,
            drsc_pkg::FN_CMP_AIN2:   map_fn = cmp_lvl;
            default:                 map_fn = 1'b0; // analog modes
        endcase
    endfunction

    assign speed_nz  = (speed_pct_i != drsc_pkg::PCT_ZERO);
    assign dig_level = map_fn(digout_function_select_i, drive_run_o,
                              fault_i, at_setpoint_i, speed_nz,
                              dig_cmp.level); // RULE1
    assign rly_level = map_fn(relay_function_select_i, drive_run_o,
                              fault_i, at_setpoint_i, speed_nz,
                              rly_cmp.level); // RULE2 RULE3

    // registered status outputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            digout_o        <= 1'b0;
            relay_contact_o <= drsc_pkg::POL_NORMALLY_OPEN;
        end else begin
            digout_o        <= dig_level;
            relay_contact_o <= rly_level ^ relay_polarity_i; // RULE6
        end
    end

    // ==========================================================
    // start sequencer decode
    drsc_pkg::drsc_seq_t state_q;
    drsc_pkg::drsc_seq_t state_d;
    logic [9:0]          timer_q;
    logic [9:0]          timer_d;
    logic [2:0]          retry_q;
    logic [2:0]          retry_d;
    logic [9:0]          hold_ticks;
    logic [2:0]          retry_max;
    logic                edge_mode;

    assign hold_ticks = (zero_speed_hold_time_i > drsc_pkg::HOLD_MAX) ?
                        drsc_pkg::HOLD_MAX : zero_speed_hold_time_i;
    assign edge_mode  = (start_mode_select_i == drsc_pkg::START_EDGE);
    assign retry_max  = (start_mode_select_i > drsc_pkg::START_AUTO0 &&
                         start_mode_select_i <= drsc_pkg::START_MAX) ?
                        (start_mode_select_i - drsc_pkg::START_AUTO0) :
                        3'h0;
    assign standby_allowed_o = (hold_ticks == drsc_pkg::TICKS_ZERO); // RULE12

    // next state
    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        retry_d = retry_q;
        case (state_q)
            drsc_pkg::SEQ_RESET: begin
                state_d = edge_mode ? drsc_pkg::SEQ_ARM
                                    : drsc_pkg::SEQ_IDLE; // RULE8 RULE9
            end
            drsc_pkg::SEQ_ARM: begin
                if (!run_sync_q) begin
                    state_d = drsc_pkg::SEQ_IDLE; // RULE8
                end
            end
            drsc_pkg::SEQ_IDLE: begin
                if (run_sync_q && !fault_i) begin
                    state_d = drsc_pkg::SEQ_RUN; // RULE9
                end
            end
            drsc_pkg::SEQ_RUN: begin
                if (fault_i) begin
                    state_d = drsc_pkg::SEQ_FAULT;
                    timer_d = drsc_pkg::TICKS_ZERO;
                end else if (!run_sync_q) begin
                    state_d = drsc_pkg::SEQ_HOLD;
                    timer_d = drsc_pkg::TICKS_ZERO;
                end
            end
            drsc_pkg::SEQ_HOLD: begin
                if (fault_i) begin
                    state_d = drsc_pkg::SEQ_FAULT;
                    timer_d = drsc_pkg::TICKS_ZERO;
                end else if (timer_q >= hold_ticks) begin
                    state_d = drsc_pkg::SEQ_IDLE; // RULE7
                end else if (tick) begin
                    timer_d = timer_q + 10'h1;
                end
            end
            drsc_pkg::SEQ_FAULT: begin
                if (fault_reset_i && !fault_i) begin
                    state_d = edge_mode ? drsc_pkg::SEQ_ARM
                                        : drsc_pkg::SEQ_IDLE;
                end else if (retry_q < retry_max) begin
                    if (timer_q >= drsc_pkg::RETRY_TICKS) begin
                        if (!fault_i && run_sync_q) begin
                            state_d = drsc_pkg::SEQ_RUN; // RULE10
                            retry_d = retry_q + 3'h1; // RULE11
                        end
                    end else if (tick) begin
                        timer_d = timer_q + 10'h1; // RULE10
                    end
                end
            end
            default: begin
                state_d = drsc_pkg::SEQ_RESET;
            end
        endcase
    end

    // state registers; retry count cleared only by power-on reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_q <= drsc_pkg::SEQ_RESET;
            timer_q <= drsc_pkg::TICKS_ZERO;
            retry_q <= 3'h0; // RULE11
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            retry_q <= retry_d;
        end
    end

    // sequencer outputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            drive_run_o       <= 1'b0;
            zero_speed_hold_o <= 1'b0;
        end else begin
            drive_run_o       <= (state_d == drsc_pkg::SEQ_RUN) ||
                                 (state_d == drsc_pkg::SEQ_HOLD); // RULE7
            zero_speed_hold_o <= (state_d == drsc_pkg::SEQ_HOLD);
        end
    end

    assign restart_count_o = retry_q;
endmodule

// ---- sim/drsc_sva.sv ----
// assertions on the ports of the status-output and start-control block
`timescale 1ns/1ps
module drsc_sva #(
    parameter int TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    // configuration and drive conditions
    input wire logic [3:0]  digout_function_select_i,
    input wire logic [11:0] digout_high_limit_i,
    input wire logic [11:0] digout_low_limit_i,
    input wire logic [3:0]  relay_function_select_i,
    input wire logic        relay_polarity_i,
    input wire logic [9:0]  zero_speed_hold_time_i,
    input wire logic [11:0] speed_pct_i,
    input wire logic        sample_valid_i,
    input wire logic        fault_i,
    // outputs
    input wire logic        digout_o,
    input wire logic        relay_contact_o,
    input wire logic        drive_run_o,
    input wire logic        zero_speed_hold_o,
    input wire logic [2:0]  restart_count_o,
    input wire logic        standby_allowed_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // cycles with the output off, cycles spent holding zero speed
    logic [31:0] off_cnt_q;
    logic [31:0] hold_cnt_q;
    wire         dig_cmp = digout_function_select_i == 4'h4;
    wire         lim_ok  = digout_high_limit_i <= drsc_pkg::PCT_MAX;
    always_ff @(posedge core_clk_i) begin
        off_cnt_q  <= (rst_i || drive_run_o) ? 32'h0 : off_cnt_q + 32'h1;
        hold_cnt_q <= zero_speed_hold_o ? hold_cnt_q + 32'h1 : 32'h0;
    end
    // ==========================================================
    // comparator samples on the speed quantity
    sequence s_dig_hi;
        dig_cmp && sample_valid_i && lim_ok
            && speed_pct_i > digout_high_limit_i;
    endsequence
    sequence s_dig_lo;
        dig_cmp && sample_valid_i && lim_ok
            && digout_low_limit_i <= digout_high_limit_i
            && speed_pct_i < digout_low_limit_i;
    endsequence
    a_dig_set: assert property (
        s_dig_hi ##1 dig_cmp |=> digout_o) else $error("digout not set");
    a_dig_clear: assert property (
        s_dig_lo ##1 dig_cmp |=> !digout_o) else $error("digout not cleared");
    a_dig_hold: assert property (
        (dig_cmp && !sample_valid_i)[*2] |=> $stable(digout_o))
        else $error("digout moved without a sample");
    a_relay_polarity: assert property (
        (relay_function_select_i == 4'h1 && $stable(relay_polarity_i)
         && $stable(fault_i))[*3]
        |-> relay_contact_o == (relay_polarity_i ^ !fault_i))
        else $error("relay contact wrong for health and polarity");
    a_hold_enabled: assert property (
        zero_speed_hold_o |-> drive_run_o) else $error("hold with output off");
    a_hold_length: assert property (
        $fell(zero_speed_hold_o) |-> hold_cnt_q <=
        32'((int'(zero_speed_hold_time_i) + 1) * TICK_CYCLES + 2))
        else $error("zero speed hold too long");
    a_fault_off: assert property (
        fault_i [*2] |-> !drive_run_o) else $error("output on during fault");
    a_count_step: assert property (
        $changed(restart_count_o)
        |-> restart_count_o == $past(restart_count_o) + 3'h1)
        else $error("restart count changed other than by one");
    a_retry_gap: assert property (
        $changed(restart_count_o) |-> off_cnt_q >=
        32'((int'(drsc_pkg::RETRY_TICKS) - 1) * TICK_CYCLES))
        else $error("restart attempt too early");
    a_standby_flag: assert property (
        standby_allowed_o == (zero_speed_hold_time_i == 10'h000))
        else $error("standby indication wrong");
endmodule

bind drsc_top drsc_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
    .core_clk_i, .rst_i, .digout_function_select_i, .digout_high_limit_i,
    .digout_low_limit_i, .relay_function_select_i, .relay_polarity_i,
    .zero_speed_hold_time_i, .speed_pct_i, .sample_valid_i, .fault_i,
    .digout_o, .relay_contact_o, .drive_run_o, .zero_speed_hold_o,
    .restart_count_o, .standby_allowed_o
);

// ---- sim/drsc_run_switch.sv ----
// model of the run switch wired to the drive's run input
`timescale 1ns/1ps
module drsc_run_switch (
    // clock of the stimulus
    input  wire logic clk_i,
    // wanted contact state, high = closed
    input  wire logic close_i,
    output logic      run_o
);
    // contact moves away from the sampling edge
    always @(negedge clk_i) begin
        run_o <= close_i;
    end
endmodule

// ---- sim/tb_top.sv ----
// self-checking testbench of the status-output and start-control block
`timescale 1ns/1ps
module tb_top;
    localparam int TICK = 4;
    // ==========================================================
    // stimulus and observed signals
    logic        clk, rst, pol, valid, at_sp, fault, frst, run_cmd, run_pin;
    logic [3:0]  dsel, rsel;
    logic [11:0] dhi, dlo, rhi, rlo, spd, trq, ain;
    logic [9:0]  hold;
    logic [2:0]  mode, cnt;
    logic        dig, rly, drun, zhold, stby;
    int          mismatches, samples_checked;
    drsc_top #(.TICK_CYCLES(TICK)) dut (
        .core_clk_i(clk), .rst_i(rst), .digout_function_select_i(dsel),
        .digout_high_limit_i(dhi), .digout_low_limit_i(dlo),
        .relay_function_select_i(rsel), .relay_high_limit_i(rhi),
        .relay_low_limit_i(rlo), .relay_polarity_i(pol),
        .zero_speed_hold_time_i(hold), .start_mode_select_i(mode),
        .speed_pct_i(spd), .torque_pct_i(trq), .ain2_pct_i(ain),
        .sample_valid_i(valid), .at_setpoint_i(at_sp), .fault_i(fault),
        .fault_reset_i(frst), .run_input_i(run_pin), .digout_o(dig),
        .relay_contact_o(rly), .drive_run_o(drun),
        .zero_speed_hold_o(zhold), .restart_count_o(cnt),
        .standby_allowed_o(stby)
    );
    drsc_run_switch u_sw (.clk_i(clk), .close_i(run_cmd), .run_o(run_pin));
    // clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================================
    // shared helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic act, input logic exp, input string msg);
        samples_checked++;
        if (act !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic chk3(input logic [2:0] act, input logic [2:0] exp);
        samples_checked++;
        if (act !== exp) begin
            mismatches++;
            $display("[FAIL] %0t restart count %0d", $time, act);
        end
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic do_reset;
        rst = 1'b1;
        cyc(16);
        rst = 1'b0;
        cyc(2);
    endtask
    task automatic smp(input logic [11:0] s, t, a);
        spd = s;
        trq = t;
        ain = a;
        valid = 1'b1;
        cyc(1);
        valid = 1'b0;
        cyc(3);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset;
        chk(dig, 1'b0, "digout not low before a sample");
        chk(drun, 1'b0, "output on after reset");
        chk(rly, 1'b1, "healthy relay open");
        chk(stby, 1'b0, "standby with hold set");
        hold = 10'h000;
        cyc(1);
        chk(stby, 1'b1, "no standby with zero hold");
        hold = 10'h002;
    endtask
    task automatic t_auto;
        run_cmd = 1'b1;
        cyc(6);
        chk(drun, 1'b1, "no automatic start");
        run_cmd = 1'b0;
        cyc(5);
        chk(zhold, 1'b1, "no zero speed hold");
        chk(drun, 1'b1, "output off during hold");
        cyc(16);
        chk(drun, 1'b0, "output not disabled after hold");
    endtask
    task automatic t_dig;
        logic [11:0] v [7] = '{12'h3e8, 12'h44c, 12'h3b6, 12'h352,
                                12'h4b0, 12'h41a, 12'h3de};
        logic        e [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 7; i++) begin
            dlo = (i < 4) ? 12'h384 : 12'h5dc;
            smp(v[i], 12'h000, 12'h000);
            chk(dig, e[i], "digout hysteresis");
        end
        // high limit above 200.0 % acts as 200.0 %
        dhi = 12'hfff;
        dlo = 12'h384;
        smp(12'h7da, 12'h000, 12'h000);
        chk(dig, 1'b1, "high limit not held to 200 percent");
        dhi = 12'h3e8;
    endtask
    task automatic t_relay;
        rsel = 4'h5;
        smp(12'h000, 12'h44c, 12'h000);
        chk(rly, 1'b1, "torque above relay high");
        pol = 1'b1;
        cyc(3);
        chk(rly, 1'b0, "inverted contact not open");
        smp(12'h000, 12'h384, 12'h000);
        chk(rly, 1'b0, "relay level not held");
        smp(12'h000, 12'h2bc, 12'h000);
        chk(rly, 1'b1, "relay level not cleared");
        pol = 1'b0;
        rsel = 4'h6;
        smp(12'h000, 12'h000, 12'h44c);
        chk(rly, 1'b1, "second analog input not compared");
        rsel = 4'h4;
        smp(12'h2bc, 12'h000, 12'h000);
        chk(rly, 1'b0, "speed not compared");
        rsel = 4'h3;
        cyc(3);
        chk(rly, 1'b1, "speed above zero");
        smp(12'h000, 12'h000, 12'h000);
        chk(rly, 1'b0, "speed at zero");
        rsel = 4'h2;
        at_sp = 1'b1;
        cyc(3);
        chk(rly, 1'b1, "at setpoint");
        rsel = 4'h0;
        cyc(3);
        chk(rly, 1'b0, "drive not running");
        rsel = 4'h1;
    endtask
    task automatic t_edge;
        mode = 3'h0;
        run_cmd = 1'b1;
        do_reset();
        cyc(8);
        chk(drun, 1'b0, "start on run held through reset");
        run_cmd = 1'b0;
        cyc(5);
        run_cmd = 1'b1;
        cyc(6);
        chk(drun, 1'b1, "no start on fresh closure");
        run_cmd = 1'b0;
        cyc(20);
    endtask
    task automatic t_retry;
        int n = 0;
        mode = 3'h2;
        do_reset();
        run_cmd = 1'b1;
        cyc(6);
        fault = 1'b1;
        cyc(3);
        chk(drun, 1'b0, "output on in fault");
        fault = 1'b0;
        cyc(400);
        chk(drun, 1'b0, "restart before interval");
        while (drun !== 1'b1 && n < 1000) begin
            cyc(1);
            n++;
        end
        chk(n >= 380 && n < 1000, 1'b1, "restart timing");
        chk3(cnt, 3'h1);
        fault = 1'b1;
        cyc(3);
        fault = 1'b0;
        cyc(1000);
        chk(drun, 1'b0, "restart beyond retry count");
        frst = 1'b1;
        cyc(1);
        frst = 1'b0;
        cyc(6);
        chk3(cnt, 3'h1);
        do_reset();
        chk3(cnt, 3'h0);
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        {rst, pol, valid, at_sp, fault, frst, run_cmd} = 7'h40;
        {dsel, rsel, mode, hold} = {4'h4, 4'h1, 3'h1, 10'h002};
        {dhi, dlo, rhi, rlo} = {12'h3e8, 12'h384, 12'h3e8, 12'h320};
        {spd, trq, ain} = 36'h0;
        mismatches = 0;
        samples_checked = 0;
        do_reset();
        t_reset();
        t_auto();
        t_dig();
        t_relay();
        t_edge();
        t_retry();
        end_of_test();
    end
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
endmodule
